// ===== vepi_top.sv
// Pixel and control input interface of a progressive-scan/HDTV video encoder
// Contract
// RULE1 - Accept 10-bit luma word each pixel
// RULE2 - RGB mode: luma port carries green
// RULE3 - Red chroma port used only in 4:4:4
// RULE4 - RGB mode: red chroma port carries red
// RULE5 - Source multiplexes Cb/Cr on combined port
// RULE6 - RGB mode: combined port carries blue
// RULE7 - Source supplies 27 or 74.25 MHz clock
// RULE8 - Blanking input marks blanking intervals
// RULE9 - Vertical pin: vsync or frame timing
// RULE10 - Horizontal pin: hsync or composite sync
// RULE11 - Low reset reinitializes timing and registers
// RULE12 - Address select pin sets address LSB
// RULE13 - Address select high enables noise filter
// RULE14 - Route luma A, red B, combined C
// RULE15 - Clock input only, data bidirectional; the code never drives data (sda_oe_n held high)
// RULE16 - Capture pixels on rising clock edge
// RULE17 - Sample controls with their pixel data
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "vepi_map.svh"
module vepi_top
  import vepi_pkg::*;
#(
  parameter int W          = 10,
  parameter int FILT_TAPS  = 5
) (
  input  wire logic         clk,
  input  wire logic         srst,
  // Pixel port, sampled on each rising edge of the pixel clock
  input  wire logic         pixel_clock_in,
  input  wire logic [W-1:0] luma_port,
  input  wire logic [W-1:0] red_chroma_port,
  input  wire logic [W-1:0] combined_color_port,
  input  wire logic         blanking_in,
  input  wire logic         vsync_frame_in,
  input  wire logic         hsync_csync_in,
  input  wire logic         reset_n_in,
  input  wire logic         address_select_pin,
  // Serial control lines
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe_n,
  // Register bus
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Output channels
  output logic      [W-1:0] chan_a,
  output logic      [W-1:0] chan_b,
  output logic      [W-1:0] chan_c,
  output logic              chan_valid,
  output logic              vsync_out,
  output logic              hsync_out,
  output logic              frame_timing_out,
  output logic              comp_sync_out,
  output logic              blank_out,
  output logic      [6:0]   serial_addr,
  output logic              scl_filt,
  output logic              sda_filt
);

  // ***************************************************************
  // Device reset: external low pin or bus reset
  // ***************************************************************
  logic       pin_rst_reg;  // Registered low-reset request
  logic       core_rst;     // Combined reset
  logic [31:0] ctrl_word;   // Control register contents
  vepi_ctrl_t ctrl;         // Decoded control fields

  // Low reset pin returns timing and registers to defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_rst_reg <= 1'b1;
    end else begin
      pin_rst_reg <= ~reset_n_in;  // RULE11
    end
  end

  assign core_rst = srst | pin_rst_reg;  // RULE11

  assign ctrl.fmt        = vepi_fmt_t'(ctrl_word[`VEPI_CTRL_FMT_LSB +: 2]);
  assign ctrl.async_mode = ctrl_word[`VEPI_CTRL_ASYNC_BIT];
  assign ctrl.hdtv       = ctrl_word[`VEPI_CTRL_HDTV_BIT];
  assign ctrl.enable     = ctrl_word[`VEPI_CTRL_EN_BIT];

  // ***************************************************************
  // Pixel clock edge detection
  // ***************************************************************
  // Pixel clock is sampled as a level; the system clock must run well above it
  logic pclk_d_reg;  // Previous pixel clock level
  wire  pclk_rise = pixel_clock_in & ~pclk_d_reg;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      pclk_d_reg <= 1'b0;
    end else begin
      pclk_d_reg <= pixel_clock_in;
    end
  end

  // ***************************************************************
  // Capture of pixel and controls on the same edge
  // ***************************************************************
  vepi_pix_t cap_reg;    // Captured pixel with controls
  logic      cap_v_reg;  // Capture valid pulse

  always_ff @(posedge clk) begin
    if (core_rst) begin
      cap_reg   <= '0;
      cap_v_reg <= 1'b0;
    end else begin
      cap_v_reg <= pclk_rise & ctrl.enable;  // RULE16
      if (pclk_rise) begin
        cap_reg.luma       <= luma_port;            // RULE1
        cap_reg.red_chroma <= red_chroma_port;
        cap_reg.combined   <= combined_color_port;
        cap_reg.blank      <= blanking_in;          // RULE8 RULE17
        cap_reg.vsync      <= vsync_frame_in;       // RULE17
        cap_reg.hsync      <= hsync_csync_in;       // RULE17
      end
    end
  end

  // ***************************************************************
  // 4:2:2 chroma demultiplex
  // ***************************************************************
  logic [W-1:0] cb_422;  // Cb half of the multiplexed stream
  logic [W-1:0] cr_422;  // Cr half of the multiplexed stream
  wire          is_422 = (ctrl.fmt == VEPI_FMT_422_YCC);

  // Source interleaves Cb and Cr on the combined port in this mode
  vepi_chroma_split #(.W(W)) u_split (  // RULE5
    .clk         (clk),
    .srst        (core_rst),
    .valid_in    (cap_v_reg & is_422),
    .blank_in    (cap_reg.blank),
    .combined_in (cap_reg.combined),
    .cb_out      (cb_422),
    .cr_out      (cr_422)
  );

  // ***************************************************************
  // Channel routing
  // ***************************************************************
  // In RGB the luma port is green, red port red, combined port blue
  wire [W-1:0] route_a = cap_reg.luma;                                 // RULE2 RULE14
  wire [W-1:0] route_b = is_422 ? cr_422 : cap_reg.red_chroma;         // RULE3 RULE4 RULE14
  wire [W-1:0] route_c = is_422 ? cb_422 : cap_reg.combined;           // RULE6 RULE14
  logic        out_v_reg;  // Delayed valid to match the split stage

  // Output channel registers, two cycles behind capture
  always_ff @(posedge clk) begin
    if (core_rst) begin
      chan_a     <= '0;
      chan_b     <= '0;
      chan_c     <= '0;
      chan_valid <= 1'b0;
      out_v_reg  <= 1'b0;
    end else begin
      out_v_reg  <= cap_v_reg;
      chan_valid <= out_v_reg;
      if (out_v_reg) begin
        chan_a <= route_a;
        chan_b <= route_b;
        chan_c <= route_c;
      end
    end
  end

  // ***************************************************************
  // Shared sync pins: standard or asynchronous timing use
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (core_rst) begin
      vsync_out        <= 1'b0;
      hsync_out        <= 1'b0;
      frame_timing_out <= 1'b0;
      comp_sync_out    <= 1'b0;
      blank_out        <= 1'b0;
    end else if (out_v_reg) begin
      vsync_out        <= ~ctrl.async_mode & cap_reg.vsync;  // RULE9
      frame_timing_out <=  ctrl.async_mode & cap_reg.vsync;  // RULE9
      hsync_out        <= ~ctrl.async_mode & cap_reg.hsync;  // RULE10
      comp_sync_out    <=  ctrl.async_mode & cap_reg.hsync;  // RULE10
      blank_out        <= cap_reg.blank;                     // RULE8
    end
  end

  // ***************************************************************
  // Line and pixel counters, timing generator state
  // ***************************************************************
  logic [31:0] line_cnt_reg;  // Lines seen since reset
  logic [31:0] pix_cnt_reg;   // Pixels in the current line
  logic        hs_d_reg;      // Previous sampled horizontal pin

  // Counters reset with the timing generator
  always_ff @(posedge clk) begin
    if (core_rst) begin
      line_cnt_reg <= 32'h0000_0000;  // RULE11
      pix_cnt_reg  <= 32'h0000_0000;
      hs_d_reg     <= 1'b0;
    end else if (cap_v_reg) begin
      hs_d_reg <= cap_reg.hsync;
      if (cap_reg.hsync & ~hs_d_reg) begin
        line_cnt_reg <= line_cnt_reg + 32'h0000_0001;
        pix_cnt_reg  <= 32'h0000_0000;
      end else if (!cap_reg.blank) begin
        pix_cnt_reg <= pix_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // ***************************************************************
  // Serial port address and noise filter
  // ***************************************************************
  logic [FILT_TAPS-1:0] scl_sh_reg;  // Glitch filter history
  logic [FILT_TAPS-1:0] sda_sh_reg;
  wire scl_all1 = &scl_sh_reg;
  wire scl_all0 = ~|scl_sh_reg;
  wire sda_all1 = &sda_sh_reg;
  wire sda_all0 = ~|sda_sh_reg;

  // Filter trades bandwidth for rejection of short pulses
  always_ff @(posedge clk) begin
    if (core_rst) begin
      serial_addr <= `VEPI_SER_ADDR_BASE;
      scl_sh_reg  <= '1;
      sda_sh_reg  <= '1;
      scl_filt    <= 1'b1;
      sda_filt    <= 1'b1;
      sda_out     <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else begin
      serial_addr <= {6'(`VEPI_SER_ADDR_BASE >> 1), address_select_pin};  // RULE12
      scl_sh_reg  <= {scl_sh_reg[FILT_TAPS-2:0], scl_in};             // RULE15
      sda_sh_reg  <= {sda_sh_reg[FILT_TAPS-2:0], sda_in};
      sda_out     <= 1'b0;
      sda_oe_n    <= 1'b1;  // RULE15
      if (!address_select_pin) begin
        scl_filt <= scl_in;  // RULE13
        sda_filt <= sda_in;
      end else begin
        if (scl_all1) scl_filt <= 1'b1;  // RULE13
        if (scl_all0) scl_filt <= 1'b0;
        if (sda_all1) sda_filt <= 1'b1;
        if (sda_all0) sda_filt <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Register bus slave
  // ***************************************************************
  wire [31:0] status_w = {25'h0, address_select_pin, ctrl.async_mode, is_422,
                          cap_reg.blank, cap_reg.vsync, cap_reg.hsync, pin_rst_reg};

  vepi_wb_slave u_wb (
    .clk         (clk),
    .srst        (core_rst),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_we_i     (wb_we_i),
    .wb_adr_i    (wb_adr_i),
    .wb_sel_i    (wb_sel_i),
    .wb_dat_i    (wb_dat_i),
    .status_in   (status_w),
    .line_cnt_in (line_cnt_reg),
    .pix_cnt_in  (pix_cnt_reg),
    .cap_a_in    ({22'h0, chan_a}),
    .cap_b_in    ({22'h0, chan_b}),
    .cap_c_in    ({22'h0, chan_c}),
    .wb_dat_o    (wb_dat_o),
    .wb_ack_o    (wb_ack_o),
    .ctrl_out    (ctrl_word)
  );
endmodule
`default_nettype wire

// ===== vepi_map.svh
// Offsets, field positions, reset values and timing counts of the video encoder input block
`ifndef VEPI_MAP_SVH
`define VEPI_MAP_SVH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define VEPI_CTRL_OFS      8'h00
`define VEPI_STATUS_OFS    8'h04
`define VEPI_LINE_CNT_OFS  8'h08
`define VEPI_PIX_CNT_OFS   8'h0c
`define VEPI_CAP_A_OFS     8'h10
`define VEPI_CAP_B_OFS     8'h14
`define VEPI_CAP_C_OFS     8'h18

// ***************************************************************
// Control field positions
// ***************************************************************
`define VEPI_CTRL_FMT_LSB   0
`define VEPI_CTRL_ASYNC_BIT 2
`define VEPI_CTRL_HDTV_BIT  3
`define VEPI_CTRL_EN_BIT    4
`define VEPI_CTRL_RESET     32'h0000_0000

// ***************************************************************
// Base serial address and low-reset minimum time
// ***************************************************************
`define VEPI_SER_ADDR_BASE  7'h2a
`define VEPI_RESET_LOW_NS   100
`define VEPI_CLK_NS         10
`define VEPI_RESET_LOW_CYC  ((`VEPI_RESET_LOW_NS + `VEPI_CLK_NS - 1) / `VEPI_CLK_NS)

`endif

// ===== vepi_pkg.sv
// Types shared by the video encoder input block
package vepi_pkg;

  // Input formats
  typedef enum logic [1:0] {
    VEPI_FMT_444_YCC,
    VEPI_FMT_422_YCC,
    VEPI_FMT_444_RGB,
    VEPI_FMT_RSVD
  } vepi_fmt_t;

  // Pixel with its controls, sampled on one edge
  typedef struct packed {
    logic [9:0] luma;
    logic [9:0] red_chroma;
    logic [9:0] combined;
    logic       blank;
    logic       vsync;
    logic       hsync;
  } vepi_pix_t;

  // Three output channel words
  typedef struct packed {
    logic [9:0] ch_a;
    logic [9:0] ch_b;
    logic [9:0] ch_c;
    logic       valid;
  } vepi_chan_t;

  // Control fields
  typedef struct packed {
    logic       enable;
    logic       hdtv;
    logic       async_mode;
    vepi_fmt_t  fmt;
  } vepi_ctrl_t;

endpackage

// ===== vepi_chroma_split.sv
// Chroma demultiplexer for the 4:2:2 combined color stream
`timescale 1ns/1ps
`default_nettype none
module vepi_chroma_split
  import vepi_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         valid_in,
  input  wire logic         blank_in,
  input  wire logic [W-1:0] combined_in,
  output logic      [W-1:0] cb_out,
  output logic      [W-1:0] cr_out
);
  // ***************************************************************
  // Phase of the multiplexed pair
  // ***************************************************************
  logic phase_reg;  // High when the next sample is Cr
  logic phase_next;

  // Phase restarts at Cb at each blanking interval so pairs stay aligned
  assign phase_next = blank_in ? 1'b0 : (valid_in ? ~phase_reg : phase_reg);

  // Phase and sample hold registers
  always_ff @(posedge clk) begin
    if (srst) begin
      phase_reg <= 1'b0;
      cb_out    <= '0;
      cr_out    <= '0;
    end else begin
      phase_reg <= phase_next;
      if (valid_in && !blank_in && !phase_reg) begin
        cb_out <= combined_in;
      end
      if (valid_in && !blank_in && phase_reg) begin
        cr_out <= combined_in;
      end
    end
  end
endmodule
`default_nettype wire

// ===== vepi_wb_slave.sv
// Classic Wishbone register slave of the video encoder input block
`timescale 1ns/1ps
`default_nettype none
`include "vepi_map.svh"
module vepi_wb_slave
  import vepi_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] status_in,
  input  wire logic [31:0] line_cnt_in,
  input  wire logic [31:0] pix_cnt_in,
  input  wire logic [31:0] cap_a_in,
  input  wire logic [31:0] cap_b_in,
  input  wire logic [31:0] cap_c_in,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [31:0] ctrl_out
);
  // ***************************************************************
  // Decode
  // ***************************************************************
  wire        req      = wb_cyc_i && wb_stb_i && !wb_ack_o;  // One ack per request
  wire        wr_ctrl  = req && wb_we_i && (wb_adr_i == `VEPI_CTRL_OFS);
  wire [31:0] byte_msk = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  logic [31:0] rd_mux;

  // Read selection; unmapped addresses read zero and still ack
  always_comb begin
    case (wb_adr_i)
      `VEPI_CTRL_OFS:     rd_mux = ctrl_out;
      `VEPI_STATUS_OFS:   rd_mux = status_in;
      `VEPI_LINE_CNT_OFS: rd_mux = line_cnt_in;
      `VEPI_PIX_CNT_OFS:  rd_mux = pix_cnt_in;
      `VEPI_CAP_A_OFS:    rd_mux = cap_a_in;
      `VEPI_CAP_B_OFS:    rd_mux = cap_b_in;
      `VEPI_CAP_C_OFS:    rd_mux = cap_c_in;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Ack one cycle after the strobe, data registered with it
  always_ff @(posedge clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_out <= `VEPI_CTRL_RESET;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) begin
        ctrl_out <= ((ctrl_out & ~byte_msk) | (wb_dat_i & byte_msk)) & 32'h0000_001f;
      end
    end
  end
endmodule
`default_nettype wire

// ===== vepi_top_props.sv
// Concurrent checks on the ports of the video encoder input block
`timescale 1ns/1ps
`default_nettype none
module vepi_top_props
  import vepi_pkg::*;
#(
  parameter int W         = 10,
  parameter int FILT_TAPS = 5
) (
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         pixel_clock_in,
  input wire logic [W-1:0] luma_port,
  input wire logic         blanking_in,
  input wire logic         vsync_frame_in,
  input wire logic         hsync_csync_in,
  input wire logic         reset_n_in,
  input wire logic         address_select_pin,
  input wire logic         sda_oe_n,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic         wb_ack_o,
  input wire logic [W-1:0] chan_a,
  input wire logic         chan_valid,
  input wire logic         vsync_out,
  input wire logic         hsync_out,
  input wire logic         frame_timing_out,
  input wire logic         comp_sync_out,
  input wire logic         blank_out,
  input wire logic [6:0]   serial_addr
);
  // ***************************************************************
  // Helper logic
  // ***************************************************************
  logic         pclk_q;   // Last pixel clock sample
  logic [2:0]   age;      // Cycles since a rise, saturates so stray pulses fail
  logic [W-1:0] luma_q;   // Luma present at the rise
  logic [2:0]   ctl_q;    // Blank, vertical, horizontal at the rise
  wire  logic   rise;     // Rise of the pixel clock
  assign rise = pixel_clock_in & ~pclk_q;
  // Record what accompanied the latest rise
  always_ff @(posedge clk) begin
    pclk_q <= srst ? 1'b0 : pixel_clock_in;
    age    <= srst ? 3'h7 : rise ? 3'h0 : (age == 3'h7) ? age : age + 3'h1;
    if (rise) begin
      luma_q <= luma_port;
      ctl_q  <= {blanking_in, vsync_frame_in, hsync_csync_in};
    end
  end
  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking dcb @(posedge clk); endclocking
  default disable iff (srst);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  AST_ACK_REQ: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i)) else $error("ack without request");
  AST_VALID_LAT: assert property (chan_valid |-> age inside {[3'h1:3'h4]})
    else $error("pixel out without a clock rise");
  AST_VALID_ONE: assert property (chan_valid |=> !chan_valid) else $error("two pulses per pixel");
  AST_LUMA_A: assert property (chan_valid |-> chan_a == luma_q)
    else $error("channel a differs from luma");
  AST_CTL_ALIGN: assert property (chan_valid |-> {blank_out, vsync_out | frame_timing_out,
    hsync_out | comp_sync_out} == ctl_q) else $error("controls not aligned with pixel");
  AST_SYNC_EXCL: assert property (!(vsync_out & frame_timing_out) && !(hsync_out & comp_sync_out))
    else $error("sync shown in both modes");
  AST_SDA_IDLE: assert property (sda_oe_n) else $error("data line driven");
  AST_ADDR_LSB: assert property (disable iff (srst || !reset_n_in)
    $past(reset_n_in, 2) && $stable(address_select_pin) |-> serial_addr == {6'h15, address_select_pin})
    else $error("address low bit wrong");
  AST_RST_QUIET: assert property (!reset_n_in |-> ##2 !chan_valid) else $error("output during reset");
  COV_WRITE: cover property (wb_ack_o && wb_we_i);
  COV_BLANK: cover property (chan_valid && blank_out);
  COV_ASYNC: cover property (chan_valid && (frame_timing_out || comp_sync_out));
endmodule
bind vepi_top vepi_top_props #(.W(W), .FILT_TAPS(FILT_TAPS)) vepi_top_props_i (.clk(clk), .srst(srst),
  .pixel_clock_in(pixel_clock_in), .luma_port(luma_port), .blanking_in(blanking_in),
  .vsync_frame_in(vsync_frame_in), .hsync_csync_in(hsync_csync_in), .reset_n_in(reset_n_in),
  .address_select_pin(address_select_pin), .sda_oe_n(sda_oe_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .chan_a(chan_a), .chan_valid(chan_valid), .vsync_out(vsync_out),
  .hsync_out(hsync_out), .frame_timing_out(frame_timing_out), .comp_sync_out(comp_sync_out),
  .blank_out(blank_out), .serial_addr(serial_addr));
`default_nettype wire

// ===== vepi_src_model.sv
// Upstream pixel source that drives the encoder input pins
`timescale 1ns/1ps
`default_nettype none
module vepi_src_model
  import vepi_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      run,
  input  wire vepi_pix_t next_pix,
  output var  logic      pclk,
  output var  vepi_pix_t pix
);
  logic [1:0] phase_reg;  // Position within one pixel period of four cycles
  // Pixel clock at a quarter rate, data held over the whole period
  always_ff @(posedge clk) begin
    if (!run) begin
      phase_reg <= 2'h0;
      pclk      <= 1'b0;  // Clock stands still between bursts
      pix       <= ~pix;  // Idle lines toggle so no stale value looks valid
    end else begin
      phase_reg <= phase_reg + 2'h1;
      pclk      <= phase_reg[0] ^ phase_reg[1];
      if (phase_reg == 2'h0) begin
        pix <= next_pix;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the video encoder input block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vepi_pkg::*;
;
  logic        clk, srst, run, reset_n_in, address_select_pin, scl_in, sda_in, lo;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pclk, pclk_q, chan_valid;
  logic        sda_out, sda_oe_n, scl_filt, sda_filt, blank_out;
  logic        vsync_out, hsync_out, frame_timing_out, comp_sync_out;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [9:0]  chan_a, chan_b, chan_c, cb_hold;
  logic [6:0]  serial_addr;
  logic [1:0]  bc_st;       // Chroma pairing: 0 unsynced, 1 expect Cb, 2 expect Cr
  vepi_pix_t   pix, next_pix;
  vepi_ctrl_t  mode;        // Mode last written to the control register
  vepi_pix_t   exp_q[$];    // Pixels awaiting their output
  vepi_chan_t  bc_q[$];     // Expected chroma channels, valid marks a known pair
  int          seed = 49720;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  always #5 clk = ~clk;
  vepi_src_model vepi_src_model_i (.clk(clk), .run(run), .next_pix(next_pix), .pclk(pclk), .pix(pix));
  vepi_top #(.W(10), .FILT_TAPS(5)) vepi_top_i (.clk(clk), .srst(srst), .pixel_clock_in(pclk),
    .luma_port(pix.luma), .red_chroma_port(pix.red_chroma), .combined_color_port(pix.combined),
    .blanking_in(pix.blank), .vsync_frame_in(pix.vsync), .hsync_csync_in(pix.hsync), .reset_n_in(reset_n_in),
    .address_select_pin(address_select_pin), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_a(chan_a),
    .chan_b(chan_b), .chan_c(chan_c), .chan_valid(chan_valid), .vsync_out(vsync_out), .hsync_out(hsync_out),
    .frame_timing_out(frame_timing_out), .comp_sync_out(comp_sync_out), .blank_out(blank_out),
    .serial_addr(serial_addr), .scl_filt(scl_filt), .sda_filt(sda_filt));
  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic vepi_pix_t rnd_pix();
    vepi_pix_t p;
    p = 33'({$random(seed), $random(seed)});
    p.blank = p.blank & p.vsync;  // Blank on a quarter of pixels
    return p;
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One classic cycle; waits for ack under a bound, data taken at that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk("wb_ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    wb(1'b0, a, 32'h0, 4'hf);
    chk("register", e, rd & m);
  endtask
  // Program a mode, then stream random pixels and drain
  task automatic burst(input vepi_ctrl_t m);
    wb(1'b1, 8'h00, 32'(m), 4'hf);
    mode = m;
    bc_st = 2'h0;
    rdchk(8'h00, 32'(m), 32'hffff_ffff);
    rdchk(8'h04, {26'h0, m.async_mode, m.fmt == VEPI_FMT_422_YCC, 4'h0}, 32'h30);
    run <= 1'b1;
    repeat (160) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ***************************************************************
  // Scoreboard: queue each pixel at its rise, check at each pulse
  // ***************************************************************
  always @(posedge clk) begin
    vepi_pix_t  e;
    vepi_chan_t b;
    next_pix <= rnd_pix();
    pclk_q   <= pclk;
    cycles++;
    if (cycles > 6000) begin
      miscompares++;
      report_and_stop();
    end
    if (!reset_n_in || srst) begin
      exp_q.delete();
      bc_q.delete();
    end else if (pclk && !pclk_q && mode.enable) begin
      b = '0;
      if (mode.fmt != VEPI_FMT_422_YCC) b = {pix.luma, pix.red_chroma, pix.combined, 1'b1};
      else if (pix.blank) bc_st = 2'h1;
      else if (bc_st == 2'h1) begin
        cb_hold = pix.combined;
        bc_st = 2'h2;
      end else if (bc_st == 2'h2) begin
        b = {pix.luma, pix.combined, cb_hold, 1'b1};
        bc_st = 2'h1;
      end
      exp_q.push_back(pix);
      bc_q.push_back(b);
    end
    if (chan_valid) begin
      if (exp_q.size() == 0) chk("chan_valid", 32'h0, 32'h1);
      else begin
        e = exp_q.pop_front();
        b = bc_q.pop_front();
        chk("chan_a", 32'(e.luma), 32'(chan_a));
        if (b.valid) chk("chan_b", 32'(b.ch_b), 32'(chan_b));
        if (b.valid) chk("chan_c", 32'(b.ch_c), 32'(chan_c));
        chk("controls", 32'({e.blank, e.vsync, e.hsync}), 32'(mode.async_mode ?
          {blank_out, frame_timing_out, comp_sync_out} : {blank_out, vsync_out, hsync_out}));
      end
    end
  end
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {clk, srst, run, reset_n_in, address_select_pin, scl_in, sda_in} = 7'b0101011;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    {mode, next_pix, bc_st, cb_hold, pclk_q} = '0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("serial_addr", 32'h2a, 32'(serial_addr));
    rdchk(8'h00, 32'h0, 32'hffff_ffff);
    rdchk(8'h20, 32'h0, 32'hffff_ffff);
    wb(1'b1, 8'h00, 32'hffff_ffff, 4'h2);
    rdchk(8'h00, 32'h0, 32'hffff_ffff);
    for (int f = 0; f < 3; f++) begin
      for (int a = 0; a < 2; a++) begin
        burst({1'b1, a[0], a[0], vepi_fmt_t'(f)});
      end
    end
    burst(5'h02);
    for (int p = 1; p >= 0; p--) begin
      address_select_pin <= p[0];
      repeat (4) @(posedge clk);
      chk("serial_addr", {25'h0, 6'h15, p[0]}, 32'(serial_addr));
      rdchk(8'h04, {25'h0, p[0], 6'h0}, 32'h40);
      {scl_in, sda_in} <= 2'b00;
      lo = 1'b1;
      for (int i = 0; i < 14; i++) begin
        @(posedge clk);
        if (i == 1) {scl_in, sda_in} <= 2'b11;
        lo &= scl_filt & sda_filt & ~sda_out;
      end
      chk("scl_filt", {31'h0, p[0]}, {31'h0, lo});
    end
    wb(1'b1, 8'h00, 32'h10, 4'hf);
    reset_n_in <= 1'b0;
    mode = '0;
    repeat (10) @(posedge clk);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk);
    run <= 1'b1;
    repeat (60) @(posedge clk);
    run <= 1'b0;
    rdchk(8'h00, 32'h0, 32'hffff_ffff);
    report_and_stop();
  end
endmodule
`default_nettype wire
